// File: inc/pvos_pkg.sv
package pvos_pkg;

    // --------------------------------------------------------------------
    // register map (byte addresses on the target port)
    // --------------------------------------------------------------------
    localparam int PVOS_AW = 8;
    localparam logic [PVOS_AW-1:0] PVOS_OFS_BLOCK_CTRL = 8'h00;
    localparam logic [PVOS_AW-1:0] PVOS_OFS_HSYNC_CTRL = 8'h04;
    localparam logic [PVOS_AW-1:0] PVOS_OFS_VSYNC_CTRL = 8'h08;
    localparam logic [PVOS_AW-1:0] PVOS_OFS_DE_HOR_CTRL = 8'h0C;
    localparam logic [PVOS_AW-1:0] PVOS_OFS_DE_VER_CTRL = 8'h10;
    localparam logic [PVOS_AW-1:0] PVOS_OFS_PAD_CTRL = 8'h14;
    localparam logic [PVOS_AW-1:0] PVOS_OFS_PAD_LEVEL = 8'h18;
    localparam logic [31:0] PVOS_REG_RST = 32'h0000_0000;

    // --------------------------------------------------------------------
    // block_control fields
    // --------------------------------------------------------------------
    localparam int PVOS_CTL_ENABLE = 0;
    localparam int PVOS_CTL_COL8 = 1;
    localparam int PVOS_CTL_DE_POL = 2;
    localparam int PVOS_CTL_CLK_POL = 3;
    localparam int PVOS_CTL_CLK_DLY = 4;
    localparam int PVOS_CTL_CLK_DIV2 = 6;
    localparam int PVOS_CTL_HS_POL = 7;
    localparam int PVOS_CTL_VS_POL = 8;
    localparam int PVOS_CTL_UNDERRUN = 16;
    localparam int PVOS_CTL_EMPTY = 17;
    localparam logic [31:0] PVOS_CTL_WMASK = 32'h0000_01FF;

    // --------------------------------------------------------------------
    // window registers: start in low half, stop in high half
    // --------------------------------------------------------------------
    localparam int PVOS_FLD_START = 0;
    localparam int PVOS_FLD_STOP = 16;

    // --------------------------------------------------------------------
    // pads
    // --------------------------------------------------------------------
    localparam int PVOS_PAD_N = 30;
    localparam int PVOS_PAD_SW_FIRST = 12;
    localparam int PVOS_PAD_SW_N = 18;
    localparam int PVOS_PAD_BIT_DE = 18;
    localparam int PVOS_PAD_BIT_VS = 19;
    localparam int PVOS_PAD_BIT_CLK = 20;
    localparam int PVOS_COL_W = 10;
    localparam int PVOS_FIFO_DEPTH = 16;
    localparam int PVOS_CNT_W = 12;
    localparam logic [1:0] PVOS_DLY_NONE = 2'h0;

    typedef enum logic [1:0] {
        PVOS_PH0 = 2'b01,
        PVOS_PH1 = 2'b10
    } pvos_phase_e;

endpackage

// File: rtl/pvos_top.sv
`timescale 1ns/100ps
// Functional notes
// - multiplexed mode: each pixel over two phases, fixed 10-bit and 8-bit pad maps
// - data enable comes only from the programmed window registers
// - data enable is built in pixel clock domain from line sync, frame reset, line count
// - hsync, vsync and data enable all leave from the same pixel clock domain
// - data enable polarity is chosen by a register bit
// - data clock output with selectable polarity and, at half rate only, one of four delays
// - data clock runs at full clock rate or half rate
// - each reconfigurable pad has a mode bit and a software level bit
// - reconfigurable pads stay push-pull outputs in both modes
// - software pad level reaches the pad at the next pixel clock edge
// - override exists for video pads 12..29, data enable, vsync and data clock
// - registers at byte offsets 0x00 to 0x18 on the dedicated target port

// ------------------------------------------------------------------------
// pixel fifo
// ------------------------------------------------------------------------
module pvos_fifo #(
    parameter int W = 30,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // fill side
    input wire logic i_in_valid,
    input wire logic [W-1:0] i_in_data,
    output logic o_in_ready,
    // drain side
    output logic o_out_valid,
    output logic [W-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
    } pvos_fifo_s;

    pvos_fifo_s q_ff;
    pvos_fifo_s nxt_q;
    logic push;
    logic pop;

    assign o_in_ready = (q_ff.count != FULL_CNT);
    assign o_out_valid = (q_ff.count != '0);
    assign o_out_data = q_ff.mem[q_ff.rd_ptr];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always_comb begin
        nxt_q = q_ff;
        if (push) begin
            nxt_q.mem[q_ff.wr_ptr] = i_in_data;
            nxt_q.wr_ptr = q_ff.wr_ptr + 1'b1;
        end
        if (pop) begin
            nxt_q.rd_ptr = q_ff.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            nxt_q.count = q_ff.count + 1'b1;
        end else if (pop && !push) begin
            nxt_q.count = q_ff.count - 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end
endmodule

// ------------------------------------------------------------------------
// panel video output stage
// ------------------------------------------------------------------------
module pvos_top import pvos_pkg::*; #(
    parameter int CNT_W = PVOS_CNT_W,
    parameter int FIFO_DEPTH = PVOS_FIFO_DEPTH
) (
    // clock and reset (clock is the output pixel clock)
    input wire logic i_core_clk,
    input wire logic i_rst,
    // register target port
    input wire logic i_reg_req,
    input wire logic i_reg_wr,
    input wire logic [PVOS_AW-1:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    output logic o_reg_ack,
    output logic [31:0] o_reg_rdata,
    // timing references from the timebase
    input wire logic i_line_sync_pixel_ref,
    input wire logic i_frame_sync_reset_ref,
    input wire logic [CNT_W-1:0] i_line_counter_ref,
    // pixel stream in
    input wire logic i_pix_valid,
    input wire logic [PVOS_COL_W-1:0] i_pix_r,
    input wire logic [PVOS_COL_W-1:0] i_pix_g,
    input wire logic [PVOS_COL_W-1:0] i_pix_b,
    output logic o_pix_ready,
    // panel pads
    output logic [PVOS_PAD_N-1:0] o_video_pad,
    output logic o_panel_data_enable_pad,
    output logic o_hsync_pad,
    output logic o_vsync_pad,
    output logic o_data_clk_pad
);
    localparam int PIX_W = 3 * PVOS_COL_W;

    typedef struct packed {
        logic [31:0] ctl;
        logic [31:0] hs;
        logic [31:0] vs;
        logic [31:0] deh;
        logic [31:0] dev;
        logic [31:0] padc;
        logic [31:0] padl;
        logic [31:0] rdata;
        logic ack;
        logic underrun;
        logic [CNT_W-1:0] hcnt;
        pvos_phase_e phase;
        logic [PVOS_PAD_N-1:0] vpad;
        logic de_pad;
        logic hs_pad;
        logic vs_pad;
        logic sw_clk;
        logic div_clk;
        logic [2:0] dly;
    } pvos_state_s;

    pvos_state_s q_ff;
    pvos_state_s nxt_q;

    logic fifo_valid;
    logic fifo_ready;
    logic [PIX_W-1:0] fifo_data;
    logic h_win;
    logic v_win;
    logic de_act;
    logic hs_act;
    logic vs_act;
    logic [PVOS_COL_W-1:0] pr;
    logic [PVOS_COL_W-1:0] pg;
    logic [PVOS_COL_W-1:0] pb;
    logic [PVOS_PAD_N-1:0] map;
    logic [PVOS_PAD_N-1:0] ovr;
    logic [PVOS_PAD_N-1:0] sw_lvl;
    logic [31:0] rd;
    logic [1:0] dly_sel;
    logic clk_tap;
    logic clk_src;

    // ------------------------------------------------------------------
    // pixel buffer: fills whenever it has room, drained one pixel per pair of phases while data enable is active
    // ------------------------------------------------------------------
    pvos_fifo #(
        .W(PIX_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_in_valid(i_pix_valid),
        .i_in_data({i_pix_r, i_pix_g, i_pix_b}),
        .o_in_ready(o_pix_ready),
        .o_out_valid(fifo_valid),
        .o_out_data(fifo_data),
        .i_out_ready(fifo_ready)
    );

    // ------------------------------------------------------------------
    // windows from programmed registers only
    // ------------------------------------------------------------------
    function automatic logic in_win(input logic [CNT_W-1:0] pos, input logic [31:0] win);
        in_win = (pos >= win[PVOS_FLD_START +: CNT_W]) && (pos < win[PVOS_FLD_STOP +: CNT_W]);
    endfunction

    assign h_win = in_win(q_ff.hcnt, q_ff.deh);
    assign v_win = in_win(i_line_counter_ref, q_ff.dev);
    assign de_act = q_ff.ctl[PVOS_CTL_ENABLE] && h_win && v_win;
    assign hs_act = q_ff.ctl[PVOS_CTL_ENABLE] && in_win(q_ff.hcnt, q_ff.hs);
    assign vs_act = q_ff.ctl[PVOS_CTL_ENABLE] && in_win(i_line_counter_ref, q_ff.vs);
    // pixel leaves the buffer at the end of its second phase
    assign fifo_ready = de_act && (q_ff.phase == PVOS_PH1);

    // ------------------------------------------------------------------
    // two-phase pad mapping; an empty buffer inside the window sends black
    // ------------------------------------------------------------------
    assign pr = fifo_valid ? fifo_data[2*PVOS_COL_W +: PVOS_COL_W] : '0;
    assign pg = fifo_valid ? fifo_data[PVOS_COL_W +: PVOS_COL_W] : '0;
    assign pb = fifo_valid ? fifo_data[0 +: PVOS_COL_W] : '0;

    always_comb begin
        map = '0;
        if (q_ff.ctl[PVOS_CTL_COL8]) begin
            // 8-bit colour takes the upper eight bits of each component
            if (q_ff.phase == PVOS_PH0) begin
                map[11:0] = {pg[5:2], pb[9:2]};
            end else begin
                map[11:0] = {pr[9:2], pg[9:6]};
            end
        end else begin
            if (q_ff.phase == PVOS_PH0) begin
                map[14:0] = {pg[8], pg[3:0], pb};
            end else begin
                map[14:0] = {pr[8:4], pr[9], pg[9], pr[3:0], pg[7:4]};
            end
        end
    end

    // ------------------------------------------------------------------
    // register read mux
    // ------------------------------------------------------------------
    always_comb begin
        rd = '0;
        if (i_reg_addr == PVOS_OFS_BLOCK_CTRL) begin
            rd = q_ff.ctl & PVOS_CTL_WMASK;
            rd[PVOS_CTL_UNDERRUN] = q_ff.underrun;
            rd[PVOS_CTL_EMPTY] = ~fifo_valid;
        end else if (i_reg_addr == PVOS_OFS_HSYNC_CTRL) begin
            rd = q_ff.hs;
        end else if (i_reg_addr == PVOS_OFS_VSYNC_CTRL) begin
            rd = q_ff.vs;
        end else if (i_reg_addr == PVOS_OFS_DE_HOR_CTRL) begin
            rd = q_ff.deh;
        end else if (i_reg_addr == PVOS_OFS_DE_VER_CTRL) begin
            rd = q_ff.dev;
        end else if (i_reg_addr == PVOS_OFS_PAD_CTRL) begin
            rd = q_ff.padc;
        end else if (i_reg_addr == PVOS_OFS_PAD_LEVEL) begin
            rd = q_ff.padl;
        end
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    assign ovr = {q_ff.padc[PVOS_PAD_SW_N-1:0], {PVOS_PAD_SW_FIRST{1'b0}}};
    // level bits share the mode bits' positions, so they move up to the first reconfigurable pad
    assign sw_lvl = {q_ff.padl[PVOS_PAD_SW_N-1:0], {PVOS_PAD_SW_FIRST{1'b0}}};

    always_comb begin
        nxt_q = q_ff;
        nxt_q.ack = i_reg_req;
        nxt_q.rdata = (i_reg_req && !i_reg_wr) ? rd : q_ff.rdata;
        if (i_reg_req && i_reg_wr) begin
            if (i_reg_addr == PVOS_OFS_BLOCK_CTRL) begin
                nxt_q.ctl = i_reg_wdata & PVOS_CTL_WMASK;
                if (i_reg_wdata[PVOS_CTL_UNDERRUN]) begin
                    nxt_q.underrun = 1'b0;
                end
            end else if (i_reg_addr == PVOS_OFS_HSYNC_CTRL) begin
                nxt_q.hs = i_reg_wdata;
            end else if (i_reg_addr == PVOS_OFS_VSYNC_CTRL) begin
                nxt_q.vs = i_reg_wdata;
            end else if (i_reg_addr == PVOS_OFS_DE_HOR_CTRL) begin
                nxt_q.deh = i_reg_wdata;
            end else if (i_reg_addr == PVOS_OFS_DE_VER_CTRL) begin
                nxt_q.dev = i_reg_wdata;
            end else if (i_reg_addr == PVOS_OFS_PAD_CTRL) begin
                nxt_q.padc = i_reg_wdata;
            end else if (i_reg_addr == PVOS_OFS_PAD_LEVEL) begin
                nxt_q.padl = i_reg_wdata;
            end
        end
        // set wins over a clear in the same cycle
        if (fifo_ready && !fifo_valid) begin
            nxt_q.underrun = 1'b1;
        end
        // horizontal position and phase restart on line sync or frame reset
        if (i_line_sync_pixel_ref || i_frame_sync_reset_ref) begin
            nxt_q.hcnt = '0;
            nxt_q.phase = PVOS_PH0;
        end else begin
            nxt_q.hcnt = q_ff.hcnt + 1'b1;
            nxt_q.phase = (q_ff.phase == PVOS_PH0) ? PVOS_PH1 : PVOS_PH0;
        end
        // pads are registered from the current state; software level lands one edge later
        nxt_q.vpad = ((de_act ? map : '0) & ~ovr) | (sw_lvl & ovr);
        nxt_q.de_pad = q_ff.padc[PVOS_PAD_BIT_DE] ? q_ff.padl[PVOS_PAD_BIT_DE]
                     : (de_act ^ q_ff.ctl[PVOS_CTL_DE_POL]);
        nxt_q.hs_pad = hs_act ^ q_ff.ctl[PVOS_CTL_HS_POL];
        nxt_q.vs_pad = q_ff.padc[PVOS_PAD_BIT_VS] ? q_ff.padl[PVOS_PAD_BIT_VS]
                     : (vs_act ^ q_ff.ctl[PVOS_CTL_VS_POL]);
        nxt_q.sw_clk = q_ff.padl[PVOS_PAD_BIT_CLK];
        // half-rate clock is high during phase 0, then delayed through a short tap line
        nxt_q.div_clk = (nxt_q.phase == PVOS_PH0);
        nxt_q.dly = {q_ff.dly[1:0], q_ff.div_clk};
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            q_ff <= '0;
            q_ff.phase <= PVOS_PH0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    // ------------------------------------------------------------------
    // data clock: delay taps act on the half-rate clock only, since a
    // full-rate clock cannot be delayed by whole cycles of itself
    // ------------------------------------------------------------------
    assign dly_sel = q_ff.ctl[PVOS_CTL_CLK_DLY +: 2];
    assign clk_tap = (dly_sel == PVOS_DLY_NONE) ? q_ff.div_clk : q_ff.dly[dly_sel - 2'h1];
    assign clk_src = q_ff.ctl[PVOS_CTL_CLK_DIV2] ? clk_tap : i_core_clk;

    // ------------------------------------------------------------------
    // outputs: every pad is push-pull, never released
    // ------------------------------------------------------------------
    assign o_reg_ack = q_ff.ack;
    assign o_reg_rdata = q_ff.rdata;
    assign o_video_pad = q_ff.vpad;
    assign o_panel_data_enable_pad = q_ff.de_pad;
    assign o_hsync_pad = q_ff.hs_pad;
    assign o_vsync_pad = q_ff.vs_pad;
    assign o_data_clk_pad = q_ff.padc[PVOS_PAD_BIT_CLK] ? q_ff.sw_clk
                          : (clk_src ^ q_ff.ctl[PVOS_CTL_CLK_POL]);
endmodule

// File: verif/pvos_top_checker.sv
`timescale 1ns/100ps
module pvos_top_checker import pvos_pkg::*; (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // register port
    input wire logic i_reg_req,
    input wire logic i_reg_wr,
    input wire logic [PVOS_AW-1:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic o_reg_ack,
    input wire logic [31:0] o_reg_rdata,
    // pads
    input wire logic [PVOS_PAD_N-1:0] o_video_pad,
    input wire logic o_panel_data_enable_pad,
    input wire logic o_vsync_pad
);
    // --------------------------------------------------------------------
    // shadow of written registers
    // --------------------------------------------------------------------
    logic [31:0] mode_ff;
    logic [31:0] lvl_ff;
    logic [31:0] ctl_ff;
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            mode_ff <= '0;
            lvl_ff <= '0;
            ctl_ff <= '0;
        end else if (i_reg_req && i_reg_wr) begin
            if (i_reg_addr == PVOS_OFS_PAD_CTRL) mode_ff <= i_reg_wdata;
            if (i_reg_addr == PVOS_OFS_PAD_LEVEL) lvl_ff <= i_reg_wdata;
            if (i_reg_addr == PVOS_OFS_BLOCK_CTRL) ctl_ff <= i_reg_wdata;
        end
    end
    // --------------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    sequence s_rd(logic [PVOS_AW-1:0] a);
        i_reg_req && !i_reg_wr && i_reg_addr == a;
    endsequence
    ack_after_a: assert property (i_reg_req |=> o_reg_ack) else $error("request without ack");
    ack_cause_a: assert property (o_reg_ack |-> $past(i_reg_req)) else $error("stray ack");
    rd_level_a: assert property (s_rd(PVOS_OFS_PAD_LEVEL) |=> o_reg_rdata == lvl_ff)
        else $error("pad level readback wrong");
    rd_hole_a: assert property (s_rd(8'h1C) |=> o_reg_rdata == 32'h0) else $error("unmapped read not zero");
    // pads follow the level one edge after the register, never in the same cycle
    pad_soft_a: assert property (((o_video_pad[29:12] ^ $past(lvl_ff[17:0])) & $past(mode_ff[17:0])) == 18'h0)
        else $error("software pad level wrong");
    de_soft_a: assert property ($past(mode_ff[18]) |-> o_panel_data_enable_pad == $past(lvl_ff[18]))
        else $error("data enable override wrong");
    vs_soft_a: assert property ($past(mode_ff[19]) |-> o_vsync_pad == $past(lvl_ff[19]))
        else $error("vsync override wrong");
    upper_zero_a: assert property ((o_video_pad[29:15] & ~$past(mode_ff[17:3])) == 15'h0)
        else $error("unused video pad driven");
    narrow_zero_a: assert property ($past(ctl_ff[PVOS_CTL_COL8]) |-> (o_video_pad[14:12] & ~$past(mode_ff[2:0])) == 3'h0)
        else $error("8-bit mode drives pads 12 to 14");
endmodule

bind pvos_top pvos_top_checker u_chk (.i_core_clk, .i_rst, .i_reg_req, .i_reg_wr, .i_reg_addr, .i_reg_wdata,
    .o_reg_ack, .o_reg_rdata, .o_video_pad, .o_panel_data_enable_pad, .o_vsync_pad);

// File: verif/pvos_panel_model.sv
`timescale 1ns/100ps
module pvos_panel_model import pvos_pkg::*; (
    // pads from the stage
    input wire logic i_data_clk,
    input wire logic i_de,
    input wire logic [PVOS_PAD_N-1:0] i_pad,
    // captured pixels
    output logic [2*PVOS_PAD_N-1:0] o_pair,
    output int o_pairs
);
    logic half = 1'b0;
    logic [PVOS_PAD_N-1:0] ph0;
    initial o_pairs = 0;
    // latch on the falling clock edge, mid-way through each pad value
    always @(negedge i_data_clk) begin
        if (!i_de) begin
            half = 1'b0;
        end else if (!half) begin
            ph0 = i_pad;
            half = 1'b1;
        end else begin
            o_pair = {i_pad, ph0};
            o_pairs = o_pairs + 1;
            half = 1'b0;
        end
    end
endmodule

// File: verif/tb_pvos_top.sv
`timescale 1ns/100ps
module tb_pvos_top import pvos_pkg::*; ;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic req = 1'b0;
    logic wr = 1'b0;
    logic ls = 1'b0;
    logic fr = 1'b0;
    logic pv = 1'b0;
    logic d0;
    logic [PVOS_AW-1:0] addr = '0;
    logic [31:0] wd = '0;
    logic [PVOS_CNT_W-1:0] lc = 12'h001;
    logic [PVOS_COL_W-1:0] pr = '0;
    logic [PVOS_COL_W-1:0] pg = 10'h1C3;
    logic [PVOS_COL_W-1:0] pb = 10'h35A;
    logic ack, rdy, de, hs, vs, dclk;
    logic [31:0] rdd;
    logic [PVOS_PAD_N-1:0] pad;
    logic [2*PVOS_PAD_N-1:0] pair;
    int pairs;
    int bad_count = 0;
    int tests_run = 0;
    int cyc = 0;
    // free-running clock: pad updates are registered in this domain
    always #5 i_core_clk = ~i_core_clk;
    pvos_top uut (.i_core_clk, .i_rst, .i_reg_req(req), .i_reg_wr(wr), .i_reg_addr(addr), .i_reg_wdata(wd),
        .o_reg_ack(ack), .o_reg_rdata(rdd), .i_line_sync_pixel_ref(ls), .i_frame_sync_reset_ref(fr),
        .i_line_counter_ref(lc), .i_pix_valid(pv), .i_pix_r(pr), .i_pix_g(pg), .i_pix_b(pb), .o_pix_ready(rdy),
        .o_video_pad(pad), .o_panel_data_enable_pad(de), .o_hsync_pad(hs), .o_vsync_pad(vs), .o_data_clk_pad(dclk));
    pvos_panel_model u_panel (.i_data_clk(dclk), .i_de(de), .i_pad(pad), .o_pair(pair), .o_pairs(pairs));
    // --------------------------------------------------------------------
    // tasks
    // --------------------------------------------------------------------
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [PVOS_AW-1:0] a, input logic [31:0] d);
        @(negedge i_core_clk);
        req = 1'b1;
        wr = w;
        addr = a;
        wd = d;
        @(negedge i_core_clk);
        req = 1'b0;
        chk(ack, 1'b1);
    endtask
    task automatic rd(input logic [PVOS_AW-1:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0);
        chk(rdd, exp);
    endtask
    task automatic push(input logic [9:0] r);
        @(negedge i_core_clk);
        pv = 1'b1;
        pr = r;
        @(negedge i_core_clk);
        pv = 1'b0;
    endtask
    task automatic line(input logic f);
        @(negedge i_core_clk);
        ls = !f;
        fr = f;
        lc = 12'h000;
        @(negedge i_core_clk);
        ls = 1'b0;
        fr = 1'b0;
        repeat (6) @(negedge i_core_clk);
    endtask
    function automatic logic [59:0] mux(input logic c8, input logic [9:0] r, input logic [9:0] g, input logic [9:0] b);
        if (c8) return {18'h0, r[9:2], g[9:6], 18'h0, g[5:2], b[9:2]};
        return {15'h0, r[8:4], r[9], g[9], r[3:0], g[7:4], 15'h0, g[8], g[3:0], b};
    endfunction
    always @(posedge i_core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            close_out();
        end
    end
    // --------------------------------------------------------------------
    // tests
    // --------------------------------------------------------------------
    initial begin
        repeat (5) @(negedge i_core_clk);
        i_rst = 1'b0;
        for (int i = 0; i < 8; i++) rd(8'(4 * i), i == 0 ? 32'h0002_0000 : 32'h0);
        for (int i = 1; i < 7; i++) begin
            acc(1'b1, 8'(4 * i), 32'h0ABC_0123 + 32'(i));
            rd(8'(4 * i), 32'h0ABC_0123 + 32'(i));
        end
        acc(1'b1, 8'h1C, 32'hFFFF_FFFF);
        rd(8'h1C, 32'h0);
        rd(8'h15, 32'h0);
        acc(1'b1, PVOS_OFS_PAD_CTRL, 32'h0);
        acc(1'b1, PVOS_OFS_PAD_LEVEL, 32'h0015_5555);
        acc(1'b1, PVOS_OFS_PAD_CTRL, 32'h001F_FFFF);
        chk(pad[29:12], 18'h0);
        @(negedge i_core_clk);
        chk({dclk, vs, de, pad[29:12]}, 21'h15_5555);
        acc(1'b1, PVOS_OFS_PAD_LEVEL, 32'h000A_AAAA);
        chk({dclk, vs, de, pad[29:12]}, 21'h15_5555);
        @(negedge i_core_clk);
        chk({dclk, vs, de, pad[29:12]}, 21'h0A_AAAA);
        acc(1'b1, PVOS_OFS_PAD_CTRL, 32'h0);
        acc(1'b1, PVOS_OFS_BLOCK_CTRL, 32'h0000_0008);
        // the full-rate data clock follows the core clock itself, so let the edge settle
        #1;
        chk(dclk, 1'b1);
        acc(1'b1, PVOS_OFS_BLOCK_CTRL, 32'h0000_0040);
        d0 = dclk;
        @(negedge i_core_clk);
        chk(dclk, !d0);
        acc(1'b1, PVOS_OFS_DE_HOR_CTRL, 32'h0004_0000);
        acc(1'b1, PVOS_OFS_DE_VER_CTRL, 32'h0001_0000);
        for (int c = 0; c < 2; c++) begin
            acc(1'b1, PVOS_OFS_BLOCK_CTRL, 32'(1 + 2 * c));
            push(10'h2A5);
            push(10'h2A6);
            chk(de, 1'b0);
            line(c[0]);
            chk(de, 1'b0);
            chk(pairs, 2 * c + 2);
            chk(pair, mux(c[0], 10'h2A6, 10'h1C3, 10'h35A));
            lc = 12'h001;
        end
        acc(1'b1, PVOS_OFS_BLOCK_CTRL, 32'h0000_0185);
        @(negedge i_core_clk);
        chk(de, 1'b1);
        chk({vs, hs}, 2'h3);
        acc(1'b1, PVOS_OFS_BLOCK_CTRL, 32'h0000_0001);
        line(1'b0);
        lc = 12'h001;
        rd(PVOS_OFS_BLOCK_CTRL, 32'h0003_0001);
        acc(1'b1, PVOS_OFS_BLOCK_CTRL, 32'h0001_0001);
        rd(PVOS_OFS_BLOCK_CTRL, 32'h0002_0001);
        // fill to capacity while no window is open, then drain two pixels a line
        @(negedge i_core_clk);
        pv = 1'b1;
        repeat (16) @(negedge i_core_clk);
        chk(rdy, 1'b0);
        pv = 1'b0;
        rd(PVOS_OFS_BLOCK_CTRL, 32'h0000_0001);
        repeat (8) line(1'b0);
        lc = 12'h001;
        rd(PVOS_OFS_BLOCK_CTRL, 32'h0002_0001);
        chk(rdy, 1'b1);
        chk(pair, mux(1'b0, 10'h2A6, 10'h1C3, 10'h35A));
        close_out();
    end
endmodule
